// ### test/t2c_pin_model.sv
// far-side pins: gate/count input and reload trigger, both pulled up when idle
module t2c_pin_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // burst request from the bench
    input  wire logic       go,
    input  wire logic       sel,
    input  wire logic [3:0] n_edges,
    input  wire logic [7:0] hold,
    // pins
    output logic            gate_count_pin,
    output logic            reload_trigger_pin,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] hl;
    logic [4:0] ph;
    logic [7:0] tm;
    logic       which;

    // a level shorter than one machine cycle could be missed, so clamp
    assign hl   = (hold < 8'h0c) ? 8'h0c : hold;
    assign busy = (ph != 5'h00);

    // each burst is n low/high pairs, every level held hl clocks
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_count_pin     <= 1'b1;
            reload_trigger_pin <= 1'b1;
            ph                 <= 5'h00;
            tm                 <= 8'h00;
            which              <= 1'b0;
        end else if (go && !busy) begin
            ph    <= {n_edges, 1'b0};
            tm    <= 8'h00;
            which <= sel;
        end else if (busy) begin
            if (tm == 8'h00) begin
                if (which) reload_trigger_pin <= !reload_trigger_pin;
                else gate_count_pin <= !gate_count_pin;
                ph <= ph - 5'h01;
                tm <= hl - 8'h01;
            end else begin
                tm <= tm - 8'h01;
            end
        end
    end
endmodule

// ### test/t2c_timer_tb_top.sv
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end

module t2c_timer_tb_top;
    import t2c_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, rst, wr, rd, go, sel, gpin, tpin, ovf, exf, busy;
    logic [7:0]  addr, wdata, rdata, hold, d, a0;
    logic [3:0]  n_ev, cmp_out, cmp_match;
    logic [15:0] w, r;
    int          error_cnt, num_checks, seed, i;
    logic [7:0]  rst_regs [16] = '{ADDR_IRQ_EN_B, ADDR_IRQ_REQ, ADDR_CMP_EN, ADDR_CMP1_LO,
        ADDR_CMP1_HI, ADDR_CMP2_LO, ADDR_CMP2_HI, ADDR_CMP3_LO, ADDR_CMP3_HI, ADDR_TCTL,
        ADDR_RLD_LO, ADDR_RLD_HI, ADDR_CNT_LO, ADDR_CNT_HI, 8'hc9, 8'hff};

    t2c_timer t2c_timer_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .gate_count_pin(gpin), .reload_trigger_pin(tpin),
        .cmp_out(cmp_out), .count_overflow_flag(ovf), .ext_reload_flag(exf),
        .cmp_match(cmp_match));
    t2c_pin_model t2c_pin_model_i (.clk(clk), .rst(rst), .go(go), .sel(sel),
        .n_edges(n_ev), .hold(hold), .gate_count_pin(gpin), .reload_trigger_pin(tpin),
        .busy(busy));

    // 50 MHz oscillator
    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr_reg(a, v[7:0]);
        wr_reg(a + 8'h01, v[15:8]);
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd_reg(a, v[7:0]);
        rd_reg(a + 8'h01, v[15:8]);
    endtask

    task automatic burst(input logic s, input logic [3:0] n, input logic [7:0] h);
        @(posedge clk);
        go <= 1'b1;
        sel <= s;
        n_ev <= n;
        hold <= h;
        @(posedge clk);
        go <= 1'b0;
    endtask

    // the model takes go on the edge at which the burst call returns, so let busy rise first
    task automatic idle_wait();
        @(posedge clk);
        for (int t = 0; t < 2000 && busy; t++) @(posedge clk);
        repeat (30) @(posedge clk);
    endtask

    task automatic ovf_wait();
        for (int t = 0; t < 100 && ovf !== 1'b1; t++) @(posedge clk) #1;
    endtask

    // expected counts over a span of clocks at one count per period
    function automatic logic [7:0] exp_counts(input int span, input int per);
        return 8'(span / per);
    endfunction

    // compare mode 0 bits keep their latch, the others take the port write
    function automatic logic [3:0] exp_port(input logic [3:0] m0, input logic [3:0] held,
                                            input logic [3:0] sw);
        return (held & m0) | (sw & ~m0);
    endfunction

    // low-byte difference over exactly k count periods
    task automatic rate_chk(input logic [7:0] ctl, input int per, input int k);
        wr_reg(ADDR_TCTL, ctl);
        rd_reg(ADDR_CNT_LO, a0);
        repeat (per * k - 2) @(posedge clk);
        rd_reg(ADDR_CNT_LO, d);
        `CHK(8'(d - a0), exp_counts(per * k, per))
    endtask

    task end_sim();
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard, far beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        {rst, wr, rd, go, sel} = 5'h11;
        {addr, wdata, n_ev} = 20'h0;
        hold = 8'h0c;
        error_cnt = 0;
        num_checks = 0;
        seed = 9169;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped places read zero
        foreach (rst_regs[j]) begin
            rd_reg(rst_regs[j], d);
            `CHK(d, RST_BYTE)
        end
        `CHK(cmp_out, RST_PORT)
        // byte-wise access to compare and reload registers
        for (i = 0; i < 8; i++) begin
            a0 = (i < 6) ? ADDR_CMP1_LO + 8'(i) : ADDR_RLD_LO + 8'(i - 6);
            w[7:0] = 8'($random(seed));
            wr_reg(a0, w[7:0]);
            rd_reg(a0, d);
            `CHK(d, w[7:0])
        end
        // prescale 1/12, 1/24 and gated with gate high
        rate_chk(8'h01, 12, 2 + ($random(seed) & 7));
        rate_chk(8'h81, 24, 2 + ($random(seed) & 7));
        rate_chk(8'h03, 12, 2 + ($random(seed) & 7));
        // gate low halts counting
        burst(1'b0, 4'h1, 8'hf0);
        repeat (40) @(posedge clk);
        rd_reg(ADDR_CNT_LO, a0);
        repeat (118) @(posedge clk);
        rd_reg(ADDR_CNT_LO, d);
        `CHK(d, a0)
        idle_wait();
        // event counting, first at the fastest legal rate
        wr_reg(ADDR_TCTL, 8'h02);
        for (i = 0; i < 4; i++) begin
            n_ev = 4'(1 + ($random(seed) & 7));
            hold = (i == 0) ? 8'h0c : 8'(12 + ($random(seed) & 15));
            rd_reg(ADDR_CNT_LO, a0);
            burst(1'b0, n_ev, hold);
            idle_wait();
            rd_reg(ADDR_CNT_LO, d);
            `CHK(8'(d - a0), 8'(n_ev))
        end
        // rollover with reload mode 0 and compare mode 0 on channel 1
        wr_reg(ADDR_TCTL, 8'h00);
        wr16(ADDR_CNT_LO, 16'hfffe);
        wr16(ADDR_RLD_LO, 16'h1234);
        wr16(ADDR_CMP1_LO, 16'h1239);
        wr_reg(ADDR_CMP_EN, 8'h08);
        wr_reg(ADDR_TCTL, 8'h11);
        ovf_wait();
        `CHK(ovf, 1'b1)
        rd16(ADDR_CNT_LO, w);
        `CHK(w, 16'h1234)
        `CHK(cmp_out[1], 1'b0)
        rd_reg(ADDR_IRQ_REQ, d);
        `CHK(d[BIT_OVF], 1'b1)
        for (i = 0; i < 100 && cmp_match[1] !== 1'b1; i++) @(posedge clk) #1;
        `CHK(cmp_match[1], 1'b1)
        rd16(ADDR_CNT_LO, w);
        `CHK(w, 16'h1239)
        `CHK(cmp_out[1], 1'b1)
        // port write moves free latches only; wait until the match has passed,
        // otherwise the standing match would hide a write that got through
        repeat (12) @(posedge clk);
        wr_reg(ADDR_CMP_PORT, 8'h00);
        repeat (2) @(posedge clk);
        `CHK(cmp_out, exp_port(4'b0010, 4'b0010, 4'h0))
        wr_reg(ADDR_IRQ_REQ, 8'h00);
        #1 `CHK(ovf, 1'b0)
        wr16(ADDR_CNT_LO, 16'hfffe);
        ovf_wait();
        repeat (2) @(posedge clk);
        `CHK(cmp_out, 4'b0000)
        // reload mode 1 on trigger fall, flag only when enabled
        wr_reg(ADDR_TCTL, 8'h1a);
        wr_reg(ADDR_IRQ_REQ, 8'h00);
        for (i = 0; i < 2; i++) begin
            r = 16'($random(seed));
            wr_reg(ADDR_IRQ_EN_B, (i == 1) ? 8'h80 : 8'h00);
            wr16(ADDR_RLD_LO, r);
            burst(1'b1, 4'h1, 8'h18);
            idle_wait();
            rd16(ADDR_CNT_LO, w);
            `CHK(w, r)
            `CHK(exf, 1'(i))
        end
        end_sim();
    end
endmodule

// ### verilog/t2c_cmp_chan.sv
module t2c_cmp_chan
    import t2c_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // counter side
    t2c_cmp_if.chan  ch
);

    logic pin_r, pin_nxt;
    logic eq_r, eq_nxt;
    logic match_r, match_nxt;

    // equality is watched continuously; match pulses once per arrival
    always_comb begin
        eq_nxt    = (ch.cnt == ch.cmp_val);
        match_nxt = eq_nxt & ~eq_r;
        pin_nxt   = pin_r;
        if (ch.mode0) begin
            // software path is cut off, only timer events move the latch
            if (eq_nxt)
                pin_nxt = 1'b1;
            else if (ch.ovf)
                pin_nxt = 1'b0;
        end else if (ch.sw_wr) begin
            pin_nxt = ch.sw_bit;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_r   <= RST_PORT[0];
            eq_r    <= 1'b0;
            match_r <= 1'b0;
        end else begin
            pin_r   <= pin_nxt;
            eq_r    <= eq_nxt;
            match_r <= match_nxt;
        end
    end

    assign ch.pin   = pin_r;
    assign ch.match = match_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_cmp_set;
        ch.mode0 && (ch.cnt == ch.cmp_val) |=> pin_r && match_r == !$past(eq_r);
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("match did not raise output");

    property p_cmp_clr;
        ch.mode0 && ch.ovf && (ch.cnt != ch.cmp_val) |=> !pin_r;
    endproperty
    a_cmp_clr: assert property (p_cmp_clr) else $error("overflow did not drop output");

    property p_sw_ignored;
        ch.mode0 && ch.sw_wr && !ch.ovf && (ch.cnt != ch.cmp_val) |=> $stable(pin_r);
    endproperty
    a_sw_ignored: assert property (p_sw_ignored) else $error("write moved compare latch");

    c_match_rise: cover property (ch.mode0 && !pin_r ##1 pin_r);
endmodule

// ### verilog/t2c_cmp_if.sv
interface t2c_cmp_if;
    logic [15:0] cnt;
    logic [15:0] cmp_val;
    logic        ovf;
    logic        mode0;
    logic        sw_wr;
    logic        sw_bit;
    logic        pin;
    logic        match;

    modport ctl  (output cnt, cmp_val, ovf, mode0, sw_wr, sw_bit, input pin, match);
    modport chan (input cnt, cmp_val, ovf, mode0, sw_wr, sw_bit, output pin, match);
endinterface

// ### verilog/t2c_pkg.sv
package t2c_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] ADDR_CMP_PORT   = 8'h90;
    localparam logic [7:0] ADDR_IRQ_EN_B   = 8'hb8;
    localparam logic [7:0] ADDR_IRQ_REQ    = 8'hc0;
    localparam logic [7:0] ADDR_CMP_EN     = 8'hc1;
    localparam logic [7:0] ADDR_CMP1_LO    = 8'hc2;
    localparam logic [7:0] ADDR_CMP1_HI    = 8'hc3;
    localparam logic [7:0] ADDR_CMP2_LO    = 8'hc4;
    localparam logic [7:0] ADDR_CMP2_HI    = 8'hc5;
    localparam logic [7:0] ADDR_CMP3_LO    = 8'hc6;
    localparam logic [7:0] ADDR_CMP3_HI    = 8'hc7;
    localparam logic [7:0] ADDR_TCTL       = 8'hc8;
    localparam logic [7:0] ADDR_RLD_LO     = 8'hca;
    localparam logic [7:0] ADDR_RLD_HI     = 8'hcb;
    localparam logic [7:0] ADDR_CNT_LO     = 8'hcc;
    localparam logic [7:0] ADDR_CNT_HI     = 8'hcd;

    // field positions
    localparam int BIT_PRESCALE = 7;  // control: 1 selects 1/24
    localparam int BIT_RLD_LSB  = 3;  // control: reload mode field [4:3]
    localparam int BIT_FN_LSB   = 0;  // control: function field [1:0]
    localparam int BIT_EXF      = 7;  // request reg: external reload flag
    localparam int BIT_OVF      = 6;  // request reg: overflow flag
    localparam int BIT_EXEN     = 7;  // enable reg b: external reload enable

    // reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0]  RST_PORT = 4'hf;
    localparam logic [15:0] CNT_ALL1 = 16'hffff;

    // machine cycle is twelve oscillator periods; clk is the oscillator
    localparam int         OSC_PER_MC = 12;
    localparam logic [3:0] MC_LAST    = 4'(OSC_PER_MC - 1);

    localparam int NUM_CH = 4;

    typedef enum logic [1:0] {
        FN_STOP  = 2'h0,
        FN_TIMER = 2'h1,
        FN_EVENT = 2'h2,
        FN_GATED = 2'h3
    } t2c_fn_t;

    localparam logic [1:0] RLD_MODE0 = 2'h2;
    localparam logic [1:0] RLD_MODE1 = 2'h3;
    localparam logic [1:0] CMP_MODE0 = 2'h2;
endpackage

// ### verilog/t2c_timer.sv
// Function
// - 16-bit counter, rollover sets overflow flag
// - timer rate oscillator over 12 or 24
// - gated mode counts only while pin high
// - gate level sampled once per machine cycle
// - event mode counts sampled falling pin edges
// - edge needs two samples, max rate 1/24
// - reload mode 0 reloads on rollover
// - reload mode 1 reloads on trigger fall
// - trigger fall sets flag when enabled
// - channels compare value with counter continuously
// - mode 0: match raises, overflow drops output
// - mode 0 ignores software port writes
// - four compare channels, 16-bit resolution
module t2c_timer
    import t2c_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // pins
    input  wire logic        gate_count_pin,
    input  wire logic        reload_trigger_pin,
    output logic      [3:0]  cmp_out,
    // request flags
    output logic             count_overflow_flag,
    output logic             ext_reload_flag,
    output logic      [3:0]  cmp_match
);

    // control and data registers
    logic [7:0]  timer_control_reg_r, timer_control_reg_nxt;
    logic [7:0]  irq_enable_reg_b_r, irq_enable_reg_b_nxt;
    logic [7:0]  cmp_en_r, cmp_en_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] rld_r, rld_nxt;
    logic [15:0] cc_r [1:3];
    logic [15:0] cc_nxt [1:3];
    logic        ovf_flag_r, ovf_flag_nxt;
    logic        exf_r, exf_nxt;
    logic        ovf_r, ovf_nxt;
    logic [7:0]  rdata_r, rdata_nxt;

    // machine cycle timing and pin samples
    logic [3:0]  mc_r, mc_nxt;
    logic        half_r, half_nxt;
    logic        gate_r, gate_nxt;
    logic        rtr_r, rtr_nxt;

    // decoded control and events
    t2c_fn_t     fn;
    logic [1:0]  rld_mode;
    logic        tick, rate_ok, inc, ev_edge, rld_edge, ovf_evt;
    logic        cnt_wr, port_wr, irq_wr;
    logic [7:0]  rd_mux;

    // control field decode
    always_comb begin
        fn       = t2c_fn_t'(timer_control_reg_r[BIT_FN_LSB +: 2]);
        rld_mode = timer_control_reg_r[BIT_RLD_LSB +: 2];
        rate_ok  = !timer_control_reg_r[BIT_PRESCALE] || half_r;
    end

    // machine cycle divider and once-per-cycle pin sampling
    always_comb begin
        tick     = (mc_r == MC_LAST);
        mc_nxt   = tick ? 4'h0 : mc_r + 4'h1;
        half_nxt = tick ? ~half_r : half_r;
        gate_nxt = tick ? gate_count_pin : gate_r;
        rtr_nxt  = tick ? reload_trigger_pin : rtr_r;
        // the pin level is caught only at the tick, so a level held
        // shorter than a machine cycle may be missed entirely
        ev_edge  = tick && gate_r && !gate_count_pin;
        rld_edge = tick && rtr_r && !reload_trigger_pin;
    end

    // count enable per function
    always_comb begin
        case (fn)
            FN_TIMER: inc = tick && rate_ok;
            FN_GATED: inc = tick && rate_ok && gate_r;
            FN_EVENT: inc = ev_edge;
            default:  inc = 1'b0;
        endcase
        ovf_evt = inc && (cnt_r == CNT_ALL1);
    end

    // write decode
    always_comb begin
        cnt_wr  = wr && (addr == ADDR_CNT_LO || addr == ADDR_CNT_HI);
        port_wr = wr && (addr == ADDR_CMP_PORT);
        irq_wr  = wr && (addr == ADDR_IRQ_REQ);
    end

    // counter, reload and software writes; a write beats the count
    always_comb begin
        cnt_nxt = cnt_r + {15'h0, inc};
        if (ovf_evt && rld_mode == RLD_MODE0)
            cnt_nxt = rld_r;
        if (rld_edge && rld_mode == RLD_MODE1)
            cnt_nxt = rld_r;
        if (wr && addr == ADDR_CNT_LO)
            cnt_nxt[7:0] = wdata;
        if (wr && addr == ADDR_CNT_HI)
            cnt_nxt[15:8] = wdata;
        rld_nxt = rld_r;
        if (wr && addr == ADDR_RLD_LO)
            rld_nxt[7:0] = wdata;
        if (wr && addr == ADDR_RLD_HI)
            rld_nxt[15:8] = wdata;
        for (int i = 1; i <= 3; i++) begin
            cc_nxt[i] = cc_r[i];
            if (wr && addr == ADDR_CMP1_LO + 8'(2 * (i - 1)))
                cc_nxt[i][7:0] = wdata;
            if (wr && addr == ADDR_CMP1_HI + 8'(2 * (i - 1)))
                cc_nxt[i][15:8] = wdata;
        end
        timer_control_reg_nxt = (wr && addr == ADDR_TCTL) ? wdata : timer_control_reg_r;
        irq_enable_reg_b_nxt  = (wr && addr == ADDR_IRQ_EN_B) ? wdata : irq_enable_reg_b_r;
        cmp_en_nxt            = (wr && addr == ADDR_CMP_EN) ? wdata : cmp_en_r;
        ovf_nxt               = ovf_evt;
    end

    // request flags: hardware set wins over a software clear
    always_comb begin
        ovf_flag_nxt = irq_wr ? wdata[BIT_OVF] : ovf_flag_r;
        exf_nxt      = irq_wr ? wdata[BIT_EXF] : exf_r;
        if (ovf_evt)
            ovf_flag_nxt = 1'b1;
        if (rld_edge && irq_enable_reg_b_r[BIT_EXEN])
            exf_nxt = 1'b1;
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        case (addr)
            ADDR_CMP_PORT: rd_mux = {4'h0, cmp_out};
            ADDR_IRQ_EN_B: rd_mux = irq_enable_reg_b_r;
            ADDR_IRQ_REQ:  rd_mux = {exf_r, ovf_flag_r, 6'h00};
            ADDR_CMP_EN:   rd_mux = cmp_en_r;
            ADDR_CMP1_LO:  rd_mux = cc_r[1][7:0];
            ADDR_CMP1_HI:  rd_mux = cc_r[1][15:8];
            ADDR_CMP2_LO:  rd_mux = cc_r[2][7:0];
            ADDR_CMP2_HI:  rd_mux = cc_r[2][15:8];
            ADDR_CMP3_LO:  rd_mux = cc_r[3][7:0];
            ADDR_CMP3_HI:  rd_mux = cc_r[3][15:8];
            ADDR_TCTL:     rd_mux = timer_control_reg_r;
            ADDR_RLD_LO:   rd_mux = rld_r[7:0];
            ADDR_RLD_HI:   rd_mux = rld_r[15:8];
            ADDR_CNT_LO:   rd_mux = cnt_r[7:0];
            ADDR_CNT_HI:   rd_mux = cnt_r[15:8];
            default:       rd_mux = RST_BYTE;
        endcase
        rdata_nxt = rd ? rd_mux : RST_BYTE;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_control_reg_r <= RST_BYTE;
            irq_enable_reg_b_r  <= RST_BYTE;
            cmp_en_r            <= RST_BYTE;
            cnt_r               <= RST_WORD;
            rld_r               <= RST_WORD;
            for (int i = 1; i <= 3; i++)
                cc_r[i] <= RST_WORD;
            ovf_flag_r          <= 1'b0;
            exf_r               <= 1'b0;
            ovf_r               <= 1'b0;
            rdata_r             <= RST_BYTE;
            mc_r                <= 4'h0;
            half_r              <= 1'b0;
            gate_r              <= 1'b0;
            rtr_r               <= 1'b0;
        end else begin
            timer_control_reg_r <= timer_control_reg_nxt;
            irq_enable_reg_b_r  <= irq_enable_reg_b_nxt;
            cmp_en_r            <= cmp_en_nxt;
            cnt_r               <= cnt_nxt;
            rld_r               <= rld_nxt;
            for (int i = 1; i <= 3; i++)
                cc_r[i] <= cc_nxt[i];
            ovf_flag_r          <= ovf_flag_nxt;
            exf_r               <= exf_nxt;
            ovf_r               <= ovf_nxt;
            rdata_r             <= rdata_nxt;
            mc_r                <= mc_nxt;
            half_r              <= half_nxt;
            gate_r              <= gate_nxt;
            rtr_r               <= rtr_nxt;
        end
    end

    // compare channels; channel 0 shares the reload register as its value
    t2c_cmp_if cif [NUM_CH] ();

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign cif[g].cnt     = cnt_r;
        assign cif[g].cmp_val = (g == 0) ? rld_r : cc_r[(g == 0) ? 1 : g];
        assign cif[g].ovf     = ovf_r;
        assign cif[g].mode0   = (cmp_en_r[2*g +: 2] == CMP_MODE0);
        assign cif[g].sw_wr   = port_wr;
        assign cif[g].sw_bit  = wdata[g];
        assign cmp_out[g]     = cif[g].pin;
        assign cmp_match[g]   = cif[g].match;

        t2c_cmp_chan u_chan (
            .clk (clk),
            .rst (rst),
            .ch  (cif[g])
        );
    end

    assign rdata               = rdata_r;
    assign count_overflow_flag = ovf_flag_r;
    assign ext_reload_flag     = exf_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_ovf_flag;
        ovf_evt && !cnt_wr |=> ovf_flag_r && cnt_r != CNT_ALL1;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("rollover lost flag");

    property p_mc_period;
        tick |-> ##12 tick;
    endproperty
    a_mc_period: assert property (p_mc_period) else $error("machine cycle not 12 clocks");

    // a control write inside the gap may legally change the rate, so the
    // next tick is judged only if it still runs the 1/24 timer
    property p_prescale24;
        fn == FN_TIMER && timer_control_reg_r[BIT_PRESCALE] && inc
            |-> ##12 (!inc || fn != FN_TIMER || !timer_control_reg_r[BIT_PRESCALE]);
    endproperty
    a_prescale24: assert property (p_prescale24) else $error("1/24 rate counted twice");

    property p_gate_halt;
        fn == FN_GATED && tick && !gate_count_pin |-> ##12 (!inc || fn != FN_GATED);
    endproperty
    a_gate_halt: assert property (p_gate_halt) else $error("counted with gate low");

    property p_gate_once;
        !tick |=> $stable(gate_r);
    endproperty
    a_gate_once: assert property (p_gate_once) else $error("gate sampled off tick");

    property p_event_inc;
        fn == FN_EVENT && tick && gate_r && !gate_count_pin && !cnt_wr
            && cnt_r != CNT_ALL1 |=> cnt_r == $past(cnt_r) + 16'h1;
    endproperty
    a_event_inc: assert property (p_event_inc) else $error("falling edge not counted");

    property p_event_gap;
        ev_edge |-> ##12 !ev_edge;
    endproperty
    a_event_gap: assert property (p_event_gap) else $error("events faster than 1/24");

    property p_reload0;
        ovf_evt && rld_mode == RLD_MODE0 && !cnt_wr |=> cnt_r == $past(rld_r);
    endproperty
    a_reload0: assert property (p_reload0) else $error("mode 0 reload missing");

    property p_reload1;
        rld_edge && rld_mode == RLD_MODE1 && !cnt_wr |=> cnt_r == $past(rld_r);
    endproperty
    a_reload1: assert property (p_reload1) else $error("mode 1 reload missing");

    property p_exf;
        rld_edge |=> exf_r == ($past(irq_enable_reg_b_r[BIT_EXEN]) ||
                               ($past(irq_wr) ? $past(wdata[BIT_EXF]) : $past(exf_r)));
    endproperty
    a_exf: assert property (p_exf) else $error("external reload flag wrong");

    property p_rd_idle;
        !rd |=> rdata_r == RST_BYTE;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

    property p_rld_wr;
        wr && addr == ADDR_RLD_HI |=> rld_r[15:8] == $past(wdata);
    endproperty
    a_rld_wr: assert property (p_rld_wr) else $error("reload high byte write lost");

    property p_timer_rate;
        fn == FN_TIMER && !timer_control_reg_r[BIT_PRESCALE] && tick |-> inc;
    endproperty
    a_timer_rate: assert property (p_timer_rate) else $error("1/12 rate missed a count");

    // without an edge, a write or a trigger reload the event counter must hold
    property p_event_hold;
        fn == FN_EVENT && !ev_edge && !cnt_wr && !rld_edge |=> $stable(cnt_r);
    endproperty
    a_event_hold: assert property (p_event_hold) else $error("count moved without edge");

    c_overflow: cover property (ovf_evt);
    c_reload1:  cover property (rld_edge && rld_mode == RLD_MODE1);
    c_event:    cover property (fn == FN_EVENT && inc);
    c_cmp0:     cover property (cmp_match[0] ##[1:1000] ovf_r);
endmodule
